// ==== hw/i2cx_expander.sv ====
// serial bus controlled eight bit port expander, top level
// Functional notes
// - With the strap low the device answers to 7-bit address 0100000.
// - The address bit zero follows the level sampled on the strap pin.
// - A direction bit of one makes its pin an input, zero an output.
// - An output pin drives the level held in its output register bit.
// - A set invert bit flips the reported level of its input pin.
// - After reset every pin is an input until direction is written.
// - A write carries a pointer byte then a data byte after the address.
// - Direction sits at pointer 3; writing 00 makes all pins outputs.
// - Output drive sits at pointer 1 and each write updates the pins.
// - All four registers can be read back by the master.
// - Direction, output and invert are writable; the level register is not.
`timescale 1ns/10ps
`default_nettype none
module i2cx_expander (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // serial bus, data line is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address strap
  input wire logic address_strap_pin,
  // port pins
  input wire logic [i2cx_pkg::I2CX_PIN_W-1:0] expander_pin_in,
  output logic [i2cx_pkg::I2CX_PIN_W-1:0] expander_pin_out,
  output logic [i2cx_pkg::I2CX_PIN_W-1:0] expander_pin_oe
);
  import i2cx_pkg::*;

  i2cx_line_if ln ();

  i2cx_state_e state_r, state_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [1:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic got_r, got_nxt;
  logic oe_r, oe_nxt;
  logic sda_out_r, sda_out_nxt;
  logic strap_r, strap_nxt;
  logic wr_en;
  logic [7:0] rd_data;

  // address byte decode: upper six fixed, bit zero from the strap
  function automatic logic addr_hit(input logic [7:0] b, input logic s);
    addr_hit = (b[7:1] == {I2CX_ADDR_HI, s});
  endfunction

  i2cx_line_sense u_sense (
    .sys_clk(sys_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ln(ln.sense)
  );

  i2cx_regs #(
    .PIN_W(I2CX_PIN_W)
  ) u_regs (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_en(wr_en),
    .ptr(ptr_r),
    .wr_data(shift_r),
    .rd_data(rd_data),
    .pin_in(expander_pin_in),
    .pin_out(expander_pin_out),
    .pin_oe(expander_pin_oe)
  );

  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    got_nxt = got_r;
    oe_nxt = oe_r;
    sda_out_nxt = I2CX_SDA_LOW;
    strap_nxt = address_strap_pin;
    wr_en = 1'b0;
    if (ln.stop) begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
      got_nxt = 1'b0;
    end else if (ln.start) begin
      // a repeated start is taken in any state
      state_nxt = ST_ADDR;
      bit_nxt = I2CX_BIT_ZERO;
      got_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (ln.scl_rise && !got_r) begin
            shift_nxt = {shift_r[6:0], ln.sda_now};
            bit_nxt = 3'(bit_r + I2CX_BIT_ONE);
            got_nxt = (bit_r == I2CX_BIT_LAST);
          end else if (ln.scl_fall && got_r) begin
            got_nxt = 1'b0;
            if (state_r == ST_ADDR) begin
              if (addr_hit(shift_r, strap_r)) begin
                rw_nxt = shift_r[0];
                oe_nxt = 1'b1;
                state_nxt = ST_ACK_ADDR;
              end else begin
                state_nxt = ST_IDLE;
              end
            end else if (state_r == ST_PTR) begin
              ptr_nxt = shift_r[1:0];
              oe_nxt = 1'b1;
              state_nxt = ST_ACK_PTR;
            end else begin
              wr_en = 1'b1;
              oe_nxt = 1'b1;
              state_nxt = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_DATA: begin
          if (ln.scl_fall) begin
            bit_nxt = I2CX_BIT_ZERO;
            if (state_r == ST_ACK_ADDR && rw_r) begin
              shift_nxt = rd_data;
              oe_nxt = !rd_data[7];
              state_nxt = ST_RDATA;
            end else begin
              oe_nxt = 1'b0;
              // further data bytes rewrite the same register
              state_nxt = (state_r == ST_ACK_ADDR) ? ST_PTR : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (ln.scl_fall) begin
            if (bit_r == I2CX_BIT_LAST) begin
              oe_nxt = 1'b0;
              bit_nxt = I2CX_BIT_ZERO;
              got_nxt = 1'b0;
              state_nxt = ST_RACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = !shift_r[6];
              bit_nxt = 3'(bit_r + I2CX_BIT_ONE);
            end
          end
        end
        ST_RACK: begin
          if (ln.scl_rise) begin
            got_nxt = !ln.sda_now;
          end else if (ln.scl_fall) begin
            got_nxt = 1'b0;
            if (got_r) begin
              shift_nxt = rd_data;
              oe_nxt = !rd_data[7];
              state_nxt = ST_RDATA;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      bit_r <= I2CX_BIT_ZERO;
      shift_r <= '0;
      ptr_r <= I2CX_PTR_LEVEL;
      rw_r <= 1'b0;
      got_r <= 1'b0;
      oe_r <= 1'b0;
      sda_out_r <= I2CX_SDA_LOW;
      strap_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      got_r <= got_nxt;
      oe_r <= oe_nxt;
      sda_out_r <= sda_out_nxt;
      strap_r <= strap_nxt;
    end
  end

  // the data line is only ever pulled low, never driven high
  assign sda_out = sda_out_r;
  assign sda_oe = oe_r;

  AST_ADDR_ACK: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_ADDR && got_r && ln.scl_fall && !ln.start && !ln.stop
      && addr_hit(shift_r, strap_r)
      |=> sda_oe && state_r == ST_ACK_ADDR)
    else $error("own address not acknowledged");

  AST_ADDR_NAK: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_ADDR && got_r && ln.scl_fall && !ln.start && !ln.stop
      && shift_r[7:1] != {I2CX_ADDR_HI, strap_r}
      |=> !sda_oe && state_r == ST_IDLE)
    else $error("foreign address acknowledged");

  AST_WRITE_AFTER_PTR: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_en |-> state_r == ST_WDATA ##1 state_r == ST_ACK_DATA && sda_oe)
    else $error("register write outside the data byte");

  AST_STOP_RELEASE: assert property (
    @(posedge sys_clk) disable iff (reset)
    ln.stop |=> !sda_oe && state_r == ST_IDLE)
    else $error("stop did not release the bus");

  AST_READ_FIRST_BIT: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_ACK_ADDR && rw_r && ln.scl_fall && !ln.start && !ln.stop
      |=> state_r == ST_RDATA && sda_oe == !$past(rd_data[7]))
    else $error("read byte not started with register msb");

  AST_STRAP_FOLLOW: assert property (
    @(posedge sys_clk) disable iff (reset)
    !$past(reset) |-> strap_r == $past(address_strap_pin))
    else $error("strap sample lost");

  AST_PTR_ACK: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_PTR && got_r && ln.scl_fall
      |=> sda_oe && state_r == ST_ACK_PTR && ptr_r == $past(shift_r[1:0]))
    else $error("pointer byte not taken or not acknowledged");

  AST_DATA_ACK: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_WDATA && got_r && ln.scl_fall
      |-> wr_en ##1 sda_oe && state_r == ST_ACK_DATA)
    else $error("data byte not written or not acknowledged");

  // a write acknowledge lets go of the line at the next clock fall so the
  // master can drive the following byte
  AST_ACK_RELEASE: assert property (
    @(posedge sys_clk) disable iff (reset)
    (state_r == ST_ACK_PTR || state_r == ST_ACK_DATA
      || (state_r == ST_ACK_ADDR && !rw_r)) && ln.scl_fall
      |=> !sda_oe)
    else $error("write acknowledge held past the clock fall");

  AST_START_RESTARTS: assert property (
    @(posedge sys_clk) disable iff (reset)
    ln.start |=> state_r == ST_ADDR && bit_r == I2CX_BIT_ZERO && !sda_oe)
    else $error("start did not restart address reception");

  AST_IDLE_QUIET: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_IDLE |-> !sda_oe)
    else $error("data line pulled while not addressed");

  AST_OUT_PINS: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_WDATA && got_r && ln.scl_fall && ptr_r == I2CX_PTR_OUT
      |=> expander_pin_out == $past(shift_r))
    else $error("output byte did not reach the port pins");

  AST_DIR_PINS: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_WDATA && got_r && ln.scl_fall && ptr_r == I2CX_PTR_DIR
      |=> expander_pin_oe == ~$past(shift_r))
    else $error("direction byte did not reach the pin enables");

  AST_READ_SHIFT: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_RDATA && ln.scl_fall && bit_r != I2CX_BIT_LAST
      |=> state_r == ST_RDATA && sda_oe == !$past(shift_r[6]))
    else $error("read bit not shifted out at the clock fall");

  AST_READ_LAST_RELEASE: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_RDATA && ln.scl_fall && bit_r == I2CX_BIT_LAST
      |=> state_r == ST_RACK && !sda_oe)
    else $error("line not released for the master acknowledge");

  // a missing acknowledge ends a read; a stop or a start also ends it in any state
  AST_READ_NAK_ENDS: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_RACK && ln.scl_fall && !got_r
      |=> state_r == ST_IDLE && !sda_oe)
    else $error("read went on after the master refused");

  AST_READ_ACK_MORE: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r == ST_RACK && ln.scl_fall && got_r
      |=> state_r == ST_RDATA && sda_oe == !$past(rd_data[7]))
    else $error("acknowledged read did not resend the register");
endmodule
`default_nettype wire

// ==== inc/i2cx_pkg.sv ====
// constants and types shared by the serial port expander
package i2cx_pkg;
  localparam int I2CX_PIN_W = 8;
  // upper six bits of the slave address, strap fills bit zero
  localparam logic [5:0] I2CX_ADDR_HI = 6'h10;
  localparam logic [1:0] I2CX_PTR_LEVEL = 2'h0;
  localparam logic [1:0] I2CX_PTR_OUT = 2'h1;
  localparam logic [1:0] I2CX_PTR_INV = 2'h2;
  localparam logic [1:0] I2CX_PTR_DIR = 2'h3;
  localparam logic [7:0] I2CX_OUT_RST = 8'hff;
  localparam logic [7:0] I2CX_INV_RST = 8'h00;
  // output enable is the inverse of direction, so all zero means inputs
  localparam logic [7:0] I2CX_OE_RST = 8'h00;
  localparam logic [2:0] I2CX_BIT_LAST = 3'h7;
  localparam logic [2:0] I2CX_BIT_ONE = 3'h1;
  localparam logic [2:0] I2CX_BIT_ZERO = 3'h0;
  localparam logic I2CX_LINE_IDLE = 1'b1;
  localparam logic I2CX_SDA_LOW = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_PTR = 4'h3,
    ST_ACK_PTR = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_DATA = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } i2cx_state_e;
endpackage

// ==== inc/i2cx_line_if.sv ====
// line events passed from the edge detector to the protocol engine
`timescale 1ns/10ps
`default_nettype none
interface i2cx_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_now;
  modport sense (output scl_rise, output scl_fall, output start,
    output stop, output sda_now);
  modport ctrl (input scl_rise, input scl_fall, input start,
    input stop, input sda_now);
endinterface
`default_nettype wire

// ==== hw/i2cx_line_sense.sv ====
// clock edge and start/stop detection on the serial bus lines
`timescale 1ns/10ps
`default_nettype none
module i2cx_line_sense (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  i2cx_line_if.sense ln
);
  import i2cx_pkg::*;

  logic scl_r, scl_nxt, sda_r, sda_nxt;

  always_comb begin
    scl_nxt = scl_in;
    sda_nxt = sda_in;
    ln.scl_rise = scl_in && !scl_r;
    ln.scl_fall = !scl_in && scl_r;
    // data moving while the clock stays high marks frame boundaries
    ln.start = scl_in && scl_r && sda_r && !sda_in;
    ln.stop = scl_in && scl_r && !sda_r && sda_in;
    ln.sda_now = sda_in;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_r <= I2CX_LINE_IDLE;
      sda_r <= I2CX_LINE_IDLE;
    end else begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== hw/i2cx_regs.sv ====
// register file and pin drivers of the port expander
`timescale 1ns/10ps
`default_nettype none
module i2cx_regs #(
  parameter int PIN_W = i2cx_pkg::I2CX_PIN_W
) (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // access port
  input wire logic wr_en,
  input wire logic [1:0] ptr,
  input wire logic [PIN_W-1:0] wr_data,
  output logic [PIN_W-1:0] rd_data,
  // pins
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe
);
  import i2cx_pkg::*;

  logic [PIN_W-1:0] out_r, out_nxt, inv_r, inv_nxt;
  logic [PIN_W-1:0] oe_r, oe_nxt, lvl_r, lvl_nxt;

  always_comb begin
    out_nxt = out_r;
    inv_nxt = inv_r;
    oe_nxt = oe_r;
    lvl_nxt = pin_in ^ inv_r;
    if (wr_en) begin
      unique case (ptr)
        I2CX_PTR_OUT: out_nxt = wr_data;
        I2CX_PTR_INV: inv_nxt = wr_data;
        I2CX_PTR_DIR: oe_nxt = ~wr_data;
        default: begin
          // level register ignores writes
        end
      endcase
    end
    unique case (ptr)
      I2CX_PTR_LEVEL: rd_data = lvl_r;
      I2CX_PTR_OUT: rd_data = out_r;
      I2CX_PTR_INV: rd_data = inv_r;
      default: rd_data = ~oe_r;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_r <= I2CX_OUT_RST;
      inv_r <= I2CX_INV_RST;
      oe_r <= I2CX_OE_RST;
      lvl_r <= '0;
    end else begin
      out_r <= out_nxt;
      inv_r <= inv_nxt;
      oe_r <= oe_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe = oe_r;

  AST_PINS_INPUT_AFTER_RESET: assert property (
    @(posedge sys_clk) disable iff (reset)
    $past(reset) |-> pin_oe == '0)
    else $error("pins not all inputs after reset");

  AST_DIR_WRITE: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_en && ptr == I2CX_PTR_DIR |=> pin_oe == ~$past(wr_data))
    else $error("direction write did not set pin enables");

  AST_OUT_WRITE: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_en && ptr == I2CX_PTR_OUT |=> pin_out == $past(wr_data))
    else $error("output write did not reach the pins");

  AST_LEVEL_NOT_WRITTEN: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_en && ptr == I2CX_PTR_LEVEL |=>
      $stable(pin_out) && $stable(pin_oe))
    else $error("level register write changed the pins");

  AST_LEVEL_INVERT: assert property (
    @(posedge sys_clk) disable iff (reset)
    ptr == I2CX_PTR_LEVEL && !$past(reset) |->
      rd_data == ($past(pin_in) ^ $past(inv_r)))
    else $error("level read does not match pins and invert mask");
endmodule
`default_nettype wire

// ==== test/i2cx_master_model.sv ====
// behavioural bus master that drives the expander's serial port
`timescale 1ns/10ps
`default_nettype none
module i2cx_master_model (
  // system
  input wire logic sys_clk,
  // bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // bus lines sit released and high until the first transfer
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // each bus phase spans four system clocks, above the three needed
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic cyc(input logic b, output logic r);
    sda_drv <= b;
    wt(4);
    scl <= 1'b1;
    wt(4);
    r = sda;
    scl <= 1'b0;
  endtask
  // also serves as repeated start from the low clock phase
  task automatic start();
    sda_drv <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sda_drv <= 1'b0;
    wt(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sda_drv <= 1'b1;
    wt(4);
  endtask
  task automatic byt(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) cyc(d[i], q[i]);
    cyc(last, a);
    ack = !a;
  endtask
  // pointer then data after the address byte
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
      output logic ok);
    logic [7:0] q;
    logic k;
    start();
    byt({a, 1'b0}, 1'b1, q, ok);
    if (ok) begin
      byt(p, 1'b1, q, k);
      byt(d, 1'b1, q, k);
    end
    stop();
    wt(4);
  endtask
  // pointer is set by a write with no data, then a repeated start
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
      output logic [7:0] v);
    logic [7:0] q;
    logic k;
    start();
    byt({a, 1'b0}, 1'b1, q, k);
    byt(p, 1'b1, q, k);
    start();
    byt({a, 1'b1}, 1'b1, q, k);
    // no acknowledge on the single data byte ends the read
    byt(8'hff, 1'b1, v, k);
    stop();
    wt(4);
  endtask
  // two bytes from the current pointer, the first one acknowledged
  task automatic rd2(input logic [6:0] a, output logic [7:0] v, w);
    logic [7:0] q;
    logic k;
    start();
    byt({a, 1'b1}, 1'b1, q, k);
    byt(8'hff, 1'b0, v, k);
    byt(8'hff, 1'b1, w, k);
    stop();
    wt(4);
  endtask
endmodule
`default_nettype wire

// ==== test/i2cx_testbench.sv ====
// self-checking bench for the serial port expander
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import i2cx_pkg::*;
  localparam int CEIL = 20000;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sda_drv, sda_out, sda_oe, strap, sda;
  logic [7:0] pin_in, pin_out, pin_oe;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  // open-drain line with pull-up: low when either side pulls
  assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
  i2cx_expander uut (
    .sys_clk(sys_clk),
    .reset(reset),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .address_strap_pin(strap),
    .expander_pin_in(pin_in),
    .expander_pin_out(pin_out),
    .expander_pin_oe(pin_oe)
  );
  i2cx_master_model m (
    .sys_clk(sys_clk),
    .sda(sda),
    .scl(scl),
    .sda_drv(sda_drv)
  );
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == CEIL) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic t_reset();
    logic [7:0] v;
    chk("pin_oe", I2CX_OE_RST, pin_oe);
    chk("pin_out", I2CX_OUT_RST, pin_out);
    m.rd(7'h20, 8'h03, v);
    chk("direction", 8'hff, v);
  endtask
  task automatic t_out();
    logic ok;
    logic [7:0] v;
    // outputs only after direction is written
    m.wr(7'h20, 8'h03, 8'h00, ok);
    chk("ack", 8'h01, {7'h00, ok});
    chk("pin_oe", 8'hff, pin_oe);
    for (int i = 0; i < 4; i++) begin
      m.wr(7'h20, 8'h01, ~(8'h11 << i), ok);
      chk("pin_out", ~(8'h11 << i), pin_out);
    end
    m.rd(7'h20, 8'h01, v);
    chk("output", 8'h77, v);
    m.rd(7'h20, 8'h03, v);
    chk("direction", 8'h00, v);
    // upper half back to inputs, lower half stays driven
    m.wr(7'h20, 8'h03, 8'hf0, ok);
    chk("pin_oe", 8'h0f, pin_oe);
  endtask
  task automatic t_inv();
    logic ok;
    logic [7:0] v;
    m.wr(7'h20, 8'h02, 8'h0f, ok);
    m.rd(7'h20, 8'h02, v);
    chk("invert", 8'h0f, v);
    m.rd(7'h20, 8'h00, v);
    chk("level", 8'h33, v);
    m.wr(7'h20, 8'h00, 8'haa, ok);
    m.rd(7'h20, 8'h00, v);
    chk("level", 8'h33, v);
  endtask
  task automatic t_strap();
    logic ok;
    strap <= 1'b1;
    m.wt(4);
    m.wr(7'h20, 8'h01, 8'h5a, ok);
    chk("ack", 8'h00, {7'h00, ok});
    chk("pin_out", 8'h77, pin_out);
    m.wr(7'h21, 8'h01, 8'h5a, ok);
    chk("pin_out", 8'h5a, pin_out);
    strap <= 1'b0;
  endtask
  // two data bytes rewrite one register, then a start to another address
  task automatic t_burst();
    logic [7:0] q, v, w;
    logic k;
    m.start();
    m.byt(8'h40, 1'b1, q, k);
    m.byt(8'h01, 1'b1, q, k);
    m.byt(8'h12, 1'b1, q, k);
    m.byt(8'h34, 1'b1, q, k);
    m.start();
    m.byt(8'h60, 1'b1, q, k);
    chk("ack", 8'h00, {7'h00, k});
    m.stop();
    m.wt(4);
    chk("pin_out", 8'h34, pin_out);
    m.rd2(7'h20, v, w);
    chk("output", 8'h34, v);
    chk("output", 8'h34, w);
  endtask
  initial begin
    strap <= 1'b0;
    pin_in <= 8'h3c;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_out();
    t_inv();
    t_strap();
    t_burst();
    finish_test();
  end
endmodule
`default_nettype wire
